// ### include/lpwt_cfg.svh
// Offsets, field positions, reset values and event constants of the wakeup timer.
// Function
// [RULE1] A 16-bit up-counter keeps counting in every power state; the code holds the count while a selected watchdog source is halted.
// [RULE2] Three-bit prescale select picks source divided by 2, 4, 8, 16 or 32.
// [RULE3] Source select bit picks sub-clock or watchdog oscillator for the prescaler.
// [RULE4] Software clears stop, then sets enable; the counter then counts up.
// [RULE5] A match with the period value restarts counting from zero.
// [RULE6] Compare-0 and wake enable both set: standby match wakes the chip via event.
// [RULE7] Watchdog oscillator halted in low power with sleep halt stops the counter.
// [RULE8] Writing one to the counter clear bit resets the counter to zero.
// [RULE9] The counter clear bit returns to zero once clearing has finished.
// [RULE10] Software writes counter clear only while counter enable is zero.
// [RULE11] The compare-0 event goes to the event link only in software standby.
// [RULE12] The compare match event is identified by event number 5Dh.
// [RULE13] After wakeup, software waits one source clock cycle before standby again.
// [RULE14] All six timer registers share one write-protect enable bit.
// [RULE15] Software keeps the compare-0 value below the period value.
// [RULE16] Software changes compare-0 and wake enable only while counting is off.
// [RULE17] The compare-0 event is a single-cycle pulse once per match.
`ifndef LPWT_CFG_SVH
`define LPWT_CFG_SVH

`define LPWT_ADDR_CTRL1 8'hb0
`define LPWT_ADDR_PERIOD 8'hb4
`define LPWT_ADDR_CMP0 8'hb8
`define LPWT_ADDR_WAKE 8'hbc
`define LPWT_ADDR_CTRL2 8'hc0
`define LPWT_ADDR_CTRL3 8'hc4
`define LPWT_ADDR_PROTECT 8'hc8
`define LPWT_ADDR_INT_STATUS 8'hcc
`define LPWT_ADDR_INT_MASK 8'hd0
`define LPWT_ADDR_COUNT 8'hd4

`define LPWT_CTRL1_PSEL_LSB 0
`define LPWT_CTRL1_CKSEL_BIT 3
`define LPWT_CTRL1_CMRE0_BIT 5
`define LPWT_CTRL2_STOP_BIT 0
`define LPWT_CTRL3_EN_BIT 0
`define LPWT_CTRL3_CLR_BIT 1
`define LPWT_WAKE_EN_BIT 15
`define LPWT_PROTECT_UNLOCK_BIT 2

`define LPWT_INT_CMP_BIT 0
`define LPWT_INT_WRAP_BIT 1
`define LPWT_INT_WAKE_BIT 2
`define LPWT_INT_WIDTH 3

`define LPWT_RST_PERIOD 16'hffff
`define LPWT_RST_CMP0 16'hffff
`define LPWT_RST_STOP 1'b1

`define LPWT_EVENT_NUMBER 8'h5d
`define LPWT_PSEL_MAX 3'h4

`endif

// ### include/lpwt_pkg.sv
// Types shared by the wakeup timer modules.
package lpwt_pkg;

  typedef struct packed {
    logic cmp0_enable;
    logic source_clock_select;
    logic [2:0] prescale_select;
  } lpwt_ctrl_type;

  typedef struct packed {
    logic compare0_enable;
    logic standby_wake_enable;
    logic standby;
  } lpwt_wake_type;

  typedef enum logic [1:0] {
    LPWT_CLR_IDLE = 2'b00,
    LPWT_CLR_WAIT = 2'b01,
    LPWT_CLR_DONE = 2'b10
  } lpwt_clr_state_type;

endpackage

// ### verilog/lpwt_source_tick.sv
// Source clock synchronisers, source select and prescale divider.
`timescale 1ns/1ps
`default_nettype none
`include "lpwt_cfg.svh"
module lpwt_source_tick
  import lpwt_pkg::*;
(
  // Clock and reset.
  input wire logic clk,
  input wire logic reset,
  // Source oscillators.
  input wire logic sub_clk,
  input wire logic wdt_clk,
  // Control.
  input wire lpwt_ctrl_type ctrl,
  input wire logic wdt_halted,
  // Ticks.
  output logic src_tick,
  output logic count_tick
);
  logic [2:0] sub_sync_reg, sub_sync_next;
  logic [2:0] wdt_sync_reg, wdt_sync_next;
  logic sub_lvl_reg, sub_lvl_next;
  logic wdt_lvl_reg, wdt_lvl_next;
  logic [4:0] div_reg, div_next;
  logic sub_rise, wdt_rise;
  logic [4:0] div_mask;

  function automatic logic [4:0] psel_mask(input logic [2:0] psel);
    logic [2:0] p;
    p = (psel > `LPWT_PSEL_MAX) ? `LPWT_PSEL_MAX : psel;
    psel_mask = 5'h1f >> (3'h4 - p);
  endfunction

  always_comb begin
    sub_sync_next = {sub_sync_reg[1:0], sub_clk};
    wdt_sync_next = {wdt_sync_reg[1:0], wdt_clk};
    sub_lvl_next = (sub_sync_reg[1] == sub_sync_reg[2]) ? sub_sync_reg[2] : sub_lvl_reg;
    wdt_lvl_next = (wdt_sync_reg[1] == wdt_sync_reg[2]) ? wdt_sync_reg[2] : wdt_lvl_reg;
    sub_rise = sub_lvl_next & ~sub_lvl_reg;
    wdt_rise = wdt_lvl_next & ~wdt_lvl_reg;
    src_tick = ctrl.source_clock_select ? (wdt_rise & ~wdt_halted) : sub_rise; // [RULE3] [RULE7]
    div_mask = psel_mask(ctrl.prescale_select);
    div_next = src_tick ? div_reg + 5'h01 : div_reg;
    count_tick = src_tick & ((div_reg & div_mask) == div_mask); // [RULE2]
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      sub_sync_reg <= 3'h0;
      wdt_sync_reg <= 3'h0;
      sub_lvl_reg <= 1'b0;
      wdt_lvl_reg <= 1'b0;
      div_reg <= 5'h00;
    end else begin
      sub_sync_reg <= sub_sync_next;
      wdt_sync_reg <= wdt_sync_next;
      sub_lvl_reg <= sub_lvl_next;
      wdt_lvl_reg <= wdt_lvl_next;
      div_reg <= div_next;
    end
  end
endmodule // lpwt_source_tick
`default_nettype wire

// ### verilog/lpwt_match_event.sv
// Compare-0 match pulse and standby wake event generation.
`timescale 1ns/1ps
`default_nettype none
`include "lpwt_cfg.svh"
module lpwt_match_event
  import lpwt_pkg::*;
#(
  parameter int WIDTH = 16
)
(
  // Clock and reset.
  input wire logic clk,
  input wire logic reset,
  // Counter state.
  input wire logic count_tick,
  input wire logic running,
  input wire logic [WIDTH-1:0] count,
  input wire logic [WIDTH-1:0] compare,
  input wire lpwt_wake_type wake,
  // Events.
  output logic match_pulse,
  output logic wake_pulse
);
  logic match_reg, match_next;
  logic wake_reg, wake_next;

  always_comb begin
    match_next = count_tick & running & wake.compare0_enable & (count == compare); // [RULE17]
    wake_next = match_next & wake.standby & wake.standby_wake_enable; // [RULE6] [RULE11]
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      match_reg <= 1'b0;
      wake_reg <= 1'b0;
    end else begin
      match_reg <= match_next;
      wake_reg <= wake_next;
    end
  end

  assign match_pulse = match_reg;
  assign wake_pulse = wake_reg;
endmodule // lpwt_match_event
`default_nettype wire

// ### verilog/lpwt_timer.sv
// Low-power wakeup timer top: APB registers, counter, clear sequence and interrupt.
//
// Added by the designer: the address map and register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "lpwt_cfg.svh"
module lpwt_timer
  import lpwt_pkg::*;
#(
  parameter int WIDTH = 16
)
(
  // Clock and reset.
  input wire logic CLK,
  input wire logic RESET,
  // APB slave.
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Source oscillators, sampled as asynchronous inputs.
  input wire logic SUB_CLK,
  input wire logic WDT_CLK,
  // Power state from the system controller.
  input wire logic STANDBY,
  input wire logic LOW_POWER,
  input wire logic WATCHDOG_SLEEP_HALT,
  // Event link and interrupt.
  output logic WAKE_EVENT,
  output logic [7:0] WAKE_EVENT_NUMBER,
  output logic IRQ
);
  lpwt_ctrl_type ctrl_reg, ctrl_next;
  logic stop_reg, stop_next;
  logic enable_reg, enable_next;
  logic clear_reg, clear_next;
  logic [WIDTH-1:0] period_reg, period_next;
  logic [WIDTH-1:0] cmp0_reg, cmp0_next;
  logic wake_en_reg, wake_en_next;
  logic unlock_reg, unlock_next;
  logic [`LPWT_INT_WIDTH-1:0] status_reg, status_next;
  logic [`LPWT_INT_WIDTH-1:0] mask_reg, mask_next;
  logic [WIDTH-1:0] count_reg, count_next;
  logic [31:0] prdata_reg, prdata_next;
  lpwt_clr_state_type clr_state_reg, clr_state_next;
  logic wr, rd, mapped, prot_ok, running, wrap;
  logic src_tick, count_tick, match_pulse, wake_pulse;
  lpwt_wake_type wake;

  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = (a == `LPWT_ADDR_CTRL1) || (a == `LPWT_ADDR_PERIOD) ||
                (a == `LPWT_ADDR_CMP0) || (a == `LPWT_ADDR_WAKE) ||
                (a == `LPWT_ADDR_CTRL2) || (a == `LPWT_ADDR_CTRL3) ||
                (a == `LPWT_ADDR_PROTECT) || (a == `LPWT_ADDR_INT_STATUS) ||
                (a == `LPWT_ADDR_INT_MASK) || (a == `LPWT_ADDR_COUNT);
  endfunction

  lpwt_source_tick u_tick (
    .clk(CLK),
    .reset(RESET),
    .sub_clk(SUB_CLK),
    .wdt_clk(WDT_CLK),
    .ctrl(ctrl_reg),
    .wdt_halted(LOW_POWER & WATCHDOG_SLEEP_HALT),
    .src_tick(src_tick),
    .count_tick(count_tick)
  );

  assign wake = {ctrl_reg.cmp0_enable, wake_en_reg, STANDBY};

  lpwt_match_event #(.WIDTH(WIDTH)) u_event (
    .clk(CLK),
    .reset(RESET),
    .count_tick(count_tick),
    .running(running),
    .count(count_reg),
    .compare(cmp0_reg),
    .wake(wake),
    .match_pulse(match_pulse),
    .wake_pulse(wake_pulse)
  );

  // Bus decode; zero wait states, read data loaded in the setup cycle.
  always_comb begin
    mapped = is_mapped(PADDR);
    wr = PSEL & PENABLE & PWRITE & mapped;
    rd = PSEL & ~PENABLE & ~PWRITE;
    prot_ok = unlock_reg; // [RULE14]
    running = enable_reg & ~stop_reg; // [RULE4] [RULE1]
    wrap = count_tick & running & (count_reg == period_reg);
  end

  // Register writes.
  always_comb begin
    ctrl_next = ctrl_reg;
    stop_next = stop_reg;
    enable_next = enable_reg;
    period_next = period_reg;
    cmp0_next = cmp0_reg;
    wake_en_next = wake_en_reg;
    unlock_next = unlock_reg;
    mask_next = mask_reg;
    if (wr && PADDR == `LPWT_ADDR_PROTECT) begin
      unlock_next = PWDATA[`LPWT_PROTECT_UNLOCK_BIT];
    end
    if (wr && PADDR == `LPWT_ADDR_INT_MASK) begin
      mask_next = PWDATA[`LPWT_INT_WIDTH-1:0];
    end
    if (wr && prot_ok) begin // [RULE14]
      unique case (PADDR)
        `LPWT_ADDR_CTRL1: begin
          ctrl_next.prescale_select = PWDATA[`LPWT_CTRL1_PSEL_LSB +: 3]; // [RULE2]
          ctrl_next.source_clock_select = PWDATA[`LPWT_CTRL1_CKSEL_BIT]; // [RULE3]
          ctrl_next.cmp0_enable = PWDATA[`LPWT_CTRL1_CMRE0_BIT];
        end
        `LPWT_ADDR_CTRL2: stop_next = PWDATA[`LPWT_CTRL2_STOP_BIT]; // [RULE4]
        `LPWT_ADDR_CTRL3: enable_next = PWDATA[`LPWT_CTRL3_EN_BIT]; // [RULE4]
        `LPWT_ADDR_PERIOD: period_next = PWDATA[WIDTH-1:0];
        `LPWT_ADDR_CMP0: cmp0_next = PWDATA[WIDTH-1:0]; // [RULE16]
        `LPWT_ADDR_WAKE: wake_en_next = PWDATA[`LPWT_WAKE_EN_BIT]; // [RULE16]
        default: begin
        end
      endcase
    end
  end

  // Counter clear sequence: it waits for one source edge, then the bit self-clears.
  always_comb begin
    clr_state_next = clr_state_reg;
    clear_next = clear_reg;
    unique case (clr_state_reg)
      LPWT_CLR_IDLE: begin
        if (clear_reg) begin
          clr_state_next = LPWT_CLR_WAIT;
        end
      end
      LPWT_CLR_WAIT: begin
        if (src_tick) begin
          clr_state_next = LPWT_CLR_DONE;
        end
      end
      LPWT_CLR_DONE: begin
        clear_next = 1'b0; // [RULE9]
        clr_state_next = LPWT_CLR_IDLE;
      end
      default: clr_state_next = LPWT_CLR_IDLE;
    endcase
    if (wr && prot_ok && PADDR == `LPWT_ADDR_CTRL3 && PWDATA[`LPWT_CTRL3_CLR_BIT]) begin
      clear_next = 1'b1; // [RULE8] [RULE10]
    end
  end

  // Counter.
  always_comb begin
    count_next = count_reg;
    if (clr_state_reg == LPWT_CLR_WAIT && src_tick) begin
      count_next = '0; // [RULE8]
    end else if (wrap) begin
      count_next = '0; // [RULE5]
    end else if (count_tick && running) begin
      count_next = count_reg + {{(WIDTH-1){1'b0}}, 1'b1}; // [RULE1] [RULE4]
    end
  end

  // Interrupt status: hardware set wins over a write-one clear.
  always_comb begin
    status_next = status_reg;
    if (wr && PADDR == `LPWT_ADDR_INT_STATUS) begin
      status_next = status_reg & ~PWDATA[`LPWT_INT_WIDTH-1:0];
    end
    if (match_pulse) begin
      status_next[`LPWT_INT_CMP_BIT] = 1'b1;
    end
    if (wrap) begin
      status_next[`LPWT_INT_WRAP_BIT] = 1'b1;
    end
    if (wake_pulse) begin
      status_next[`LPWT_INT_WAKE_BIT] = 1'b1;
    end
  end

  // Read data.
  always_comb begin
    prdata_next = prdata_reg;
    if (rd) begin
      prdata_next = 32'h0;
      unique case (PADDR)
        `LPWT_ADDR_CTRL1: begin
          prdata_next[`LPWT_CTRL1_PSEL_LSB +: 3] = ctrl_reg.prescale_select;
          prdata_next[`LPWT_CTRL1_CKSEL_BIT] = ctrl_reg.source_clock_select;
          prdata_next[`LPWT_CTRL1_CMRE0_BIT] = ctrl_reg.cmp0_enable;
        end
        `LPWT_ADDR_CTRL2: prdata_next[`LPWT_CTRL2_STOP_BIT] = stop_reg;
        `LPWT_ADDR_CTRL3: begin
          prdata_next[`LPWT_CTRL3_EN_BIT] = enable_reg;
          prdata_next[`LPWT_CTRL3_CLR_BIT] = clear_reg; // [RULE9]
        end
        `LPWT_ADDR_PERIOD: prdata_next[WIDTH-1:0] = period_reg;
        `LPWT_ADDR_CMP0: prdata_next[WIDTH-1:0] = cmp0_reg;
        `LPWT_ADDR_WAKE: prdata_next[`LPWT_WAKE_EN_BIT] = wake_en_reg;
        `LPWT_ADDR_PROTECT: prdata_next[`LPWT_PROTECT_UNLOCK_BIT] = unlock_reg;
        `LPWT_ADDR_INT_STATUS: prdata_next[`LPWT_INT_WIDTH-1:0] = status_reg;
        `LPWT_ADDR_INT_MASK: prdata_next[`LPWT_INT_WIDTH-1:0] = mask_reg;
        `LPWT_ADDR_COUNT: prdata_next[WIDTH-1:0] = count_reg;
        default: prdata_next = 32'h0;
      endcase
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      ctrl_reg <= '0;
      stop_reg <= `LPWT_RST_STOP;
      enable_reg <= 1'b0;
      clear_reg <= 1'b0;
      period_reg <= `LPWT_RST_PERIOD;
      cmp0_reg <= `LPWT_RST_CMP0;
      wake_en_reg <= 1'b0;
      unlock_reg <= 1'b0;
      status_reg <= '0;
      mask_reg <= '0;
      count_reg <= '0;
      prdata_reg <= 32'h0;
      clr_state_reg <= LPWT_CLR_IDLE;
    end else begin
      ctrl_reg <= ctrl_next;
      stop_reg <= stop_next;
      enable_reg <= enable_next;
      clear_reg <= clear_next;
      period_reg <= period_next;
      cmp0_reg <= cmp0_next;
      wake_en_reg <= wake_en_next;
      unlock_reg <= unlock_next;
      status_reg <= status_next;
      mask_reg <= mask_next;
      count_reg <= count_next;
      prdata_reg <= prdata_next;
      clr_state_reg <= clr_state_next;
    end
  end

  assign PRDATA = prdata_reg;
  assign PREADY = 1'b1;
  assign PSLVERR = PSEL & PENABLE & ~mapped;
  assign WAKE_EVENT = wake_pulse; // [RULE6] [RULE11] [RULE17]
  assign WAKE_EVENT_NUMBER = `LPWT_EVENT_NUMBER; // [RULE12]
  assign IRQ = |(status_reg & mask_reg);
endmodule // lpwt_timer
`default_nettype wire

// ### test/lpwt_timer_checker.sv
// Port assertions for the wakeup timer top.
`timescale 1ns/1ps
`default_nettype none
module lpwt_timer_checker (
  // Clock and reset.
  input wire logic CLK,
  input wire logic RESET,
  // Bus.
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic PSLVERR,
  // Power and events.
  input wire logic STANDBY,
  input wire logic LOW_POWER,
  input wire logic WATCHDOG_SLEEP_HALT,
  input wire logic WAKE_EVENT,
  input wire logic [7:0] WAKE_EVENT_NUMBER,
  input wire logic IRQ
);
  logic wr;
  logic [2:0] mask_reg, mask_next;
  logic wdt_reg, wdt_next;
  assign wr = PSEL && PENABLE && PWRITE;
  always_comb begin
    mask_next = (wr && PADDR == 8'hd0) ? PWDATA[2:0] : mask_reg;
    wdt_next = (wr && PADDR == 8'hb0) ? PWDATA[3] : wdt_reg;
  end
  always_ff @(posedge CLK) begin
    mask_reg <= RESET ? 3'h0 : mask_next;
    wdt_reg <= RESET ? 1'b0 : wdt_next;
  end
  default clocking @(posedge CLK); endclocking
  default disable iff (RESET);
  sequence s_halted;
    (wdt_reg && LOW_POWER && WATCHDOG_SLEEP_HALT) [*8];
  endsequence
  sequence s_bad_read;
    PSEL && !PENABLE && !PWRITE && PADDR == 8'hd8 ##1 PENABLE;
  endsequence
  chk_event_number: assert property (WAKE_EVENT_NUMBER == 8'h5d)
    else $error("wrong event number");
  chk_event_standby: assert property (WAKE_EVENT |-> $past(STANDBY))
    else $error("event outside standby");
  chk_event_single: assert property (WAKE_EVENT |=> !WAKE_EVENT [*8])
    else $error("event not a single pulse");
  chk_halt_quiet: assert property (s_halted |-> !WAKE_EVENT)
    else $error("event while source halted");
  chk_unmapped_err: assert property (s_bad_read |-> PSLVERR && PRDATA == 32'h0)
    else $error("unmapped read not refused");
  chk_reset_quiet: assert property ($fell(RESET) |-> !IRQ && !WAKE_EVENT)
    else $error("outputs busy after reset");
  chk_irq_wake: assert property (WAKE_EVENT && mask_reg[2] |-> ##[0:3] IRQ)
    else $error("wake did not raise irq");
  chk_irq_masked: assert property (mask_reg == 3'h0 |-> !IRQ)
    else $error("irq while all masked");
endmodule // lpwt_timer_checker
bind lpwt_timer lpwt_timer_checker u_checker (.CLK, .RESET, .PSEL, .PENABLE, .PWRITE,
  .PADDR, .PWDATA, .PRDATA, .PSLVERR, .STANDBY, .LOW_POWER, .WATCHDOG_SLEEP_HALT,
  .WAKE_EVENT, .WAKE_EVENT_NUMBER, .IRQ);
`default_nettype wire

// ### test/lpwt_osc_elc_model.sv
// Oscillator and event link model facing the wakeup timer.
`timescale 1ns/1ps
`default_nettype none
module lpwt_osc_elc_model #(
  parameter int HALF = 8
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic reset,
  // Power state.
  input wire logic halt_wdt,
  // Oscillators.
  output logic sub_clk = 1'b0,
  output logic wdt_clk = 1'b0,
  // Event link.
  input wire logic wake_event,
  input wire logic [7:0] wake_number,
  output int event_total = 0
);
  int phase = 0;
  always @(posedge clk) begin
    phase <= (phase == HALF - 1) ? 0 : phase + 1;
    if (phase == HALF - 1) begin
      sub_clk <= !sub_clk;
      if (!halt_wdt) wdt_clk <= !wdt_clk;
    end
    if (reset) event_total <= 0;
    else if (wake_event && wake_number == 8'h5d) event_total <= event_total + 1;
  end
endmodule // lpwt_osc_elc_model
`default_nettype wire

// ### test/test_low_power_wakeup_timer.sv
// Self-checking bench for the wakeup timer.
`timescale 1ns/1ps
`default_nettype none
module test_low_power_wakeup_timer;
  logic CLK = 1'b0;
  logic RESET = 1'b1;
  logic PSEL = 1'b0;
  logic PENABLE = 1'b0;
  logic PWRITE = 1'b0;
  logic [7:0] PADDR = 8'h0;
  logic [31:0] PWDATA = 32'h0;
  logic STANDBY = 1'b0;
  logic LOW_POWER = 1'b1;
  logic WATCHDOG_SLEEP_HALT = 1'b1;
  logic [31:0] PRDATA, rd;
  logic PREADY, PSLVERR, SUB_CLK, WDT_CLK, WAKE_EVENT, IRQ;
  logic [7:0] WAKE_EVENT_NUMBER;
  logic [32:0] notes[$];
  logic [15:0] per;
  int fail_count = 0;
  int total_checks = 0;
  int cyc = 0;
  int events, t0, t1;
  always #2 CLK = !CLK;
  always @(posedge CLK) cyc <= cyc + 1;
  lpwt_timer u_dut (.CLK, .RESET, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA,
    .PREADY, .PSLVERR, .SUB_CLK, .WDT_CLK, .STANDBY, .LOW_POWER, .WATCHDOG_SLEEP_HALT,
    .WAKE_EVENT, .WAKE_EVENT_NUMBER, .IRQ);
  lpwt_osc_elc_model u_osc (.clk(CLK), .reset(RESET),
    .halt_wdt(LOW_POWER && WATCHDOG_SLEEP_HALT), .sub_clk(SUB_CLK), .wdt_clk(WDT_CLK),
    .wake_event(WAKE_EVENT), .wake_number(WAKE_EVENT_NUMBER), .event_total(events));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic chk, input logic [31:0] exp);
    int n;
    @(posedge CLK);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    if (!w) notes.push_back({chk, exp});
    @(posedge CLK);
    PENABLE <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge CLK);
      if (PREADY === 1'b1) break;
    end
    if (n == 50) begin
      fail_count++;
      give_verdict();
    end
    rd = PRDATA;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask
  // Read results are compared in arrival order against the noted values.
  always @(posedge CLK) begin
    if (PSEL && PENABLE && !PWRITE && PREADY === 1'b1 && notes.size() > 0) begin
      if (notes[0][32]) check(PRDATA, notes[0][31:0]);
      void'(notes.pop_front());
    end
  end
  task automatic restart(input logic [31:0] ctrl);
    int n;
    bus(1, 8'hc4, 32'h0, 0, 0);
    bus(1, 8'hc4, 32'h2, 0, 0);
    for (n = 0; n < 100; n++) begin
      bus(0, 8'hc4, 0, 0, 0);
      if (rd[1] === 1'b0) break;
    end
    check({31'h0, rd[1]}, 32'h0);
    if (n == 100) give_verdict();
    bus(0, 8'hd4, 0, 1, 32'h0);
    bus(1, 8'hb0, ctrl, 0, 0);
    bus(1, 8'hc4, 32'h1, 0, 0);
  endtask
  task automatic wait_event(output int at);
    int n;
    @(posedge CLK);
    for (n = 0; n < 5000 && WAKE_EVENT !== 1'b1; n++) @(posedge CLK);
    if (n == 5000) begin
      fail_count++;
      give_verdict();
    end
    at = cyc;
  endtask
  initial begin
    void'($urandom(32'h07a44f1e));
    repeat (5) @(posedge CLK);
    RESET <= 1'b0;
    bus(0, 8'hb4, 0, 1, 32'hffff);
    bus(0, 8'hb8, 0, 1, 32'hffff);
    bus(0, 8'hc0, 0, 1, 32'h1);
    bus(0, 8'hc4, 0, 1, 32'h0);
    bus(0, 8'hd8, 0, 1, 32'h0);
    bus(1, 8'hb4, 32'h5, 0, 0);
    bus(0, 8'hb4, 0, 1, 32'hffff);
    bus(1, 8'hc8, 32'h4, 0, 0);
    bus(1, 8'hd0, 32'h7, 0, 0);
    bus(1, 8'hb4, 32'hff, 0, 0);
    bus(1, 8'hc0, 32'h0, 0, 0);
    // Low power with the watchdog halt active must not stop the sub-clock source.
    for (int p = 0; p < 5; p++) begin
      restart(32'(p));
      repeat (128 << p) @(posedge CLK);
      bus(1, 8'hc4, 32'h0, 0, 0);
      bus(0, 8'hd4, 0, 0, 0);
      check(32'(rd >= 3 && rd <= 5), 32'h1);
    end
    restart(32'h8);
    repeat (300) @(posedge CLK);
    bus(0, 8'hd4, 0, 1, 32'h0);
    LOW_POWER <= 1'b0;
    repeat (300) @(posedge CLK);
    bus(0, 8'hd4, 0, 0, 0);
    check(32'(rd > 3), 32'h1);
    bus(1, 8'hc4, 32'h0, 0, 0);
    per = 16'(3 + $urandom % 6);
    bus(1, 8'hb4, 32'(per), 0, 0);
    bus(1, 8'hb8, 32'($urandom % per), 0, 0);
    bus(1, 8'hbc, 32'h8000, 0, 0);
    restart(32'h20);
    repeat (64 * (per + 1)) @(posedge CLK);
    check(32'(events), 32'h0);
    bus(0, 8'hcc, 0, 1, 32'h3);
    bus(1, 8'hcc, 32'h7, 0, 0);
    STANDBY <= 1'b1;
    wait_event(t0);
    wait_event(t1);
    check(32'(t1 - t0), 32'(32 * (per + 1)));
    @(posedge CLK);
    check(32'(events), 32'h2);
    check({31'h0, IRQ}, 32'h1);
    bus(1, 8'hd0, 32'h0, 0, 0);
    @(posedge CLK);
    check({31'h0, IRQ}, 32'h0);
    STANDBY <= 1'b0;
    repeat (16) @(posedge CLK);
    STANDBY <= 1'b1;
    wait_event(t0);
    @(posedge CLK);
    check(32'(events), 32'h3);
    STANDBY <= 1'b0;
    give_verdict();
  end
endmodule // test_low_power_wakeup_timer
`default_nettype wire
